/* File: hw/wsm_pkg.sv */
// constants, register layouts and helper functions of the wind speed threshold monitor
package wsm_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ       = 25_000_000;
	localparam int unsigned TICK_S       = 1;
	localparam int unsigned TICK_CYC     = CLK_HZ * TICK_S;
	localparam logic [3:0]  SEND_DELAY_S = 4'hA;
	localparam logic [3:0]  CYC_UNIT_S   = 4'hA;
	localparam logic [6:0]  CYC_MAX      = 7'h78;

	// ---------------------------------------------------------------
	// value scaling, all speeds in 0.01 m/s
	// ---------------------------------------------------------------
	localparam logic [15:0] SPAN_LO    = 16'h0064;
	localparam logic [15:0] SPAN_HI    = 16'h0BB8;
	localparam logic [15:0] EXT8_SCALE = 16'h0064;

	// ---------------------------------------------------------------
	// register map and codes
	// ---------------------------------------------------------------
	localparam logic [7:0]  ADR_CFG   = 8'h00;
	localparam logic [7:0]  ADR_CYC   = 8'h04;
	localparam logic [7:0]  ADR_STAT  = 8'h08;
	localparam logic [7:0]  ADR_LEVEL = 8'h0C;
	localparam logic [31:0] CFG_RST   = 32'h0000_0000;
	localparam logic [31:0] CYC_RST   = 32'h0000_0000;
	localparam logic [1:0]  MODE_NONE = 2'h0;
	localparam logic [1:0]  EXT_NO    = 2'h0;
	localparam logic [1:0]  EXT_16    = 2'h1;
	localparam logic [1:0]  EXT_8     = 2'h2;
	localparam logic [1:0]  EXT_TEACH = 2'h3;

	typedef struct packed {
		logic [5:0] rsv;
		logic       soc;
		logic [3:0] off_dly;
		logic [3:0] on_dly;
		logic [1:0] ext;
		logic [3:0] act;
		logic [2:0] hyst;
		logic [3:0] lvl;
		logic [1:0] step;
		logic [1:0] mode;
	} wsm_cfg_t;

	typedef struct packed {
		logic [16:0] rsv;
		logic [6:0]  thr_cyc;
		logic        rsv2;
		logic [6:0]  meas_cyc;
	} wsm_cyc_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
		wsm_cfg_t    cfg;
		wsm_cyc_t    cyc;
		logic [24:0] div;
		logic        tick;
		logic [3:0]  sec;
		logic        dec;
		logic [15:0] meas;
		logic [15:0] last;
		logic        chg_pend;
		logic [3:0]  chg_tmr;
		logic [6:0]  mcyc_cnt;
		logic        meas_send;
		logic [15:0] frame;
		logic        ext_ok;
		logic [15:0] ext_val;
		logic        raw;
		logic        flag;
		logic        dly_run;
		logic [11:0] dly_tmr;
		logic [6:0]  tcyc_cnt;
		logic        thr_send;
	} wsm_state_t;

	// ---------------------------------------------------------------
	// lookup functions
	// ---------------------------------------------------------------
	function automatic logic [15:0] wsm_level(input logic [3:0] i);
		case (i)
			4'h0:    return 16'h0064;
			4'h1:    return 16'h012C;
			4'h2:    return 16'h01F4;
			4'h3:    return 16'h0320;
			4'h4:    return 16'h03E8;
			4'h5:    return 16'h04B0;
			4'h6:    return 16'h05DC;
			4'h7:    return 16'h07D0;
			4'h8:    return 16'h0898;
			4'h9:    return 16'h09C4;
			4'hA:    return 16'h0BB8;
			default: return 16'h0DAC;
		endcase
	endfunction

	function automatic logic [15:0] wsm_hyst(input logic [2:0] i);
		case (i)
			3'h1:    return 16'h0064;
			3'h2:    return 16'h012C;
			3'h3:    return 16'h01F4;
			3'h4:    return 16'h0320;
			3'h5:    return 16'h03E8;
			default: return 16'h0000;
		endcase
	endfunction

	function automatic logic [15:0] wsm_step(input logic [1:0] i);
		case (i)
			2'h0:    return 16'h000F;
			2'h1:    return 16'h001E;
			2'h2:    return 16'h005A;
			default: return 16'h012C;
		endcase
	endfunction

	function automatic logic [11:0] wsm_delay(input logic [3:0] i);
		case (i)
			4'h1:    return 12'h001;
			4'h2:    return 12'h003;
			4'h3:    return 12'h005;
			4'h4:    return 12'h00A;
			4'h5:    return 12'h00F;
			4'h6:    return 12'h01E;
			4'h7:    return 12'h03C;
			4'h8:    return 12'h0B4;
			4'h9:    return 12'h12C;
			4'hA:    return 12'h258;
			4'hB:    return 12'h384;
			4'hC:    return 12'h708;
			4'hD:    return 12'hE10;
			default: return 12'h000;
		endcase
	endfunction

endpackage

/* File: hw/wsm_monitor.sv */
// wind speed reporting and threshold monitor with a classic wishbone register slave
`timescale 1ns/1ps
`default_nettype none

module wsm_monitor
	import wsm_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	input  wire logic        meas_valid_in,
	input  wire logic [15:0] meas_in,
	input  wire logic        ext16_valid_in,
	input  wire logic [15:0] ext16_in,
	input  wire logic        ext8_valid_in,
	input  wire logic [7:0]  ext8_in,
	input  wire logic        teach_in,
	output logic             meas_send_out,
	output logic      [15:0] meas_frame_out,
	output logic             thr_send_out,
	output logic             thr_flag_out
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// two-byte float: mantissa times 0.01, exponent shifts until it fits 11 bits
	function automatic logic [15:0] float_enc(input logic [15:0] v);
		logic [15:0] m;
		logic [3:0]  e;
		m = v;
		e = 4'h0;
		for (int i = 0; i < 5; i++) begin
			if (m > 16'h07FF) begin
				m = m >> 1;
				e = e + 4'h1;
			end
		end
		return {1'b0, e, m[10:0]};
	endfunction

	function automatic logic [15:0] clamp_span(input logic [15:0] v);
		if (v < SPAN_LO) begin
			return SPAN_LO;
		end else if (v > SPAN_HI) begin
			return SPAN_HI;
		end
		return v;
	endfunction

	function automatic logic [6:0] cyc_lim(input logic [6:0] c);
		return (c > CYC_MAX) ? CYC_MAX : c;
	endfunction

	wsm_state_t s_r;
	wsm_state_t s_nxt;

	logic        bus_req;
	logic        wr_fire;
	logic        dl_fire;
	logic        thr_on;
	logic        rising;
	logic [15:0] level;
	logic [15:0] hyst;
	logic [16:0] lo_lvl;
	logic [16:0] hi_lvl;
	logic        a_val;
	logic        a_none;
	logic        b_val;
	logic        b_none;
	logic        want;
	logic        quiet;
	logic [11:0] dly_tgt;
	logic [15:0] diff;
	logic        chg_go;
	logic        cyc_go;

	// ---------------------------------------------------------------
	// combinational decode
	// ---------------------------------------------------------------
	always_comb begin
		bus_req = wb_cyc_in && wb_stb_in;
		// a write lands on the edge where the master sees ack
		wr_fire = bus_req && wb_we_in && s_r.ack;
		dl_fire = wr_fire && (wb_adr_in == ADR_CFG);
		thr_on  = (s_r.cfg.mode != MODE_NONE);
		rising  = !s_r.cfg.act[1];
		level   = (s_r.ext_ok && s_r.cfg.ext != EXT_NO) ? s_r.ext_val
			: wsm_level(s_r.cfg.lvl);
		hyst    = wsm_hyst(s_r.cfg.hyst);
		lo_lvl  = (level > hyst) ? {1'b0, level - hyst} : 17'h00000;
		hi_lvl  = {1'b0, level} + {1'b0, hyst};
		// action codes: 0..3 both send, 4..7 second silent, 8..11 first silent
		a_val   = !s_r.cfg.act[0];
		a_none  = s_r.cfg.act[3];
		b_val   = s_r.cfg.act[0];
		b_none  = (s_r.cfg.act[3:2] == 2'h1);
		want    = s_r.raw ? a_val : b_val;
		quiet   = s_r.raw ? a_none : b_none;
		dly_tgt = want ? wsm_delay(s_r.cfg.on_dly) : wsm_delay(s_r.cfg.off_dly);
		diff    = (s_r.meas > s_r.last) ? s_r.meas - s_r.last : s_r.last - s_r.meas;
		chg_go  = s_r.chg_pend && s_r.tick && (s_r.chg_tmr == SEND_DELAY_S - 4'h1);
		cyc_go  = s_r.dec && (cyc_lim(s_r.cyc.meas_cyc) != 7'h00)
			&& (s_r.mcyc_cnt + 7'h01 >= cyc_lim(s_r.cyc.meas_cyc));
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt           = s_r;
		s_nxt.meas_send = 1'b0;
		s_nxt.thr_send  = 1'b0;
		s_nxt.tick      = 1'b0;
		s_nxt.dec       = 1'b0;

		// bus slave: ack one cycle after the request, dropped the cycle after
		s_nxt.ack = bus_req && !s_r.ack;
		if (bus_req && !s_r.ack) begin
			case (wb_adr_in)
				ADR_CFG:   s_nxt.dat = s_r.cfg;
				ADR_CYC:   s_nxt.dat = s_r.cyc;
				ADR_STAT:  s_nxt.dat = {11'h000, s_r.chg_pend, s_r.dly_run,
					s_r.ext_ok, s_r.raw, s_r.flag, s_r.meas};
				ADR_LEVEL: s_nxt.dat = {16'h0000, level};
				default:   s_nxt.dat = 32'h0000_0000;
			endcase
		end
		if (wr_fire && wb_adr_in == ADR_CFG) begin
			s_nxt.cfg = merge_sel(s_r.cfg, wb_dat_in, wb_sel_in);
		end
		if (wr_fire && wb_adr_in == ADR_CYC) begin
			s_nxt.cyc = merge_sel(s_r.cyc, wb_dat_in, wb_sel_in);
		end

		// one second tick and ten second unit
		if (s_r.div == 25'(TICK_CYCLES - 1)) begin
			s_nxt.div  = 25'h0000000;
			s_nxt.tick = 1'b1;
			s_nxt.sec  = (s_r.sec == CYC_UNIT_S - 4'h1) ? 4'h0 : s_r.sec + 4'h1;
			s_nxt.dec  = (s_r.sec == CYC_UNIT_S - 4'h1);
		end else begin
			s_nxt.div = s_r.div + 25'h0000001;
		end

		if (meas_valid_in) begin
			s_nxt.meas = clamp_span(meas_in);
		end

		// change-driven value send behind a fixed delay
		if (!s_r.chg_pend && diff >= wsm_step(s_r.cfg.step)) begin
			s_nxt.chg_pend = 1'b1;
			s_nxt.chg_tmr  = 4'h0;
		end else if (s_r.chg_pend && s_r.tick) begin
			s_nxt.chg_tmr = s_r.chg_tmr + 4'h1;
		end
		if (chg_go) begin
			s_nxt.chg_pend = 1'b0;
			s_nxt.last     = s_r.meas;
		end
		// cyclic value send has its own counter and leaves the change path alone
		if (cyc_lim(s_r.cyc.meas_cyc) == 7'h00) begin
			s_nxt.mcyc_cnt = 7'h00;
		end else if (s_r.dec) begin
			s_nxt.mcyc_cnt = cyc_go ? 7'h00 : s_r.mcyc_cnt + 7'h01;
		end
		if (chg_go || cyc_go) begin
			s_nxt.meas_send = 1'b1;
			s_nxt.frame     = float_enc(s_r.meas);
		end

		// external threshold; a download forces the configured level back unless an external value or teach arrives in the same cycle
		if (dl_fire) begin
			s_nxt.ext_ok = 1'b0;
		end
		if (s_r.cfg.ext == EXT_16 && ext16_valid_in) begin
			s_nxt.ext_ok  = 1'b1;
			s_nxt.ext_val = ext16_in;
		end
		if (s_r.cfg.ext == EXT_8 && ext8_valid_in) begin
			s_nxt.ext_ok  = 1'b1;
			s_nxt.ext_val = 16'({8'h00, ext8_in} * EXT8_SCALE);
		end
		if (s_r.cfg.ext == EXT_TEACH && teach_in) begin
			s_nxt.ext_ok  = 1'b1;
			s_nxt.ext_val = s_r.meas;
		end

		// comparator; between the two levels the state is kept
		if (thr_on && rising) begin
			if ({1'b0, s_r.meas} > {1'b0, level}) begin
				s_nxt.raw = 1'b1;
			end else if ({1'b0, s_r.meas} < lo_lvl) begin
				s_nxt.raw = 1'b0;
			end
		end else if (thr_on) begin
			if (s_r.meas < level) begin
				s_nxt.raw = 1'b1;
			end else if ({1'b0, s_r.meas} > hi_lvl) begin
				s_nxt.raw = 1'b0;
			end
		end

		// delayed acceptance; a reversal before expiry cancels the timer
		if (!thr_on || quiet || want == s_r.flag) begin
			s_nxt.dly_run = 1'b0;
		end else if (dly_tgt == 12'h000
			|| (s_r.dly_run && s_r.tick && s_r.dly_tmr + 12'h001 >= dly_tgt)) begin
			s_nxt.flag     = want;
			s_nxt.dly_run  = 1'b0;
			s_nxt.thr_send = s_r.cfg.soc;
		end else if (!s_r.dly_run) begin
			s_nxt.dly_run = 1'b1;
			s_nxt.dly_tmr = 12'h000;
		end else if (s_r.tick) begin
			s_nxt.dly_tmr = s_r.dly_tmr + 12'h001;
		end

		// cyclic flag send repeats the accepted flag, not the raw state
		if (cyc_lim(s_r.cyc.thr_cyc) == 7'h00) begin
			s_nxt.tcyc_cnt = 7'h00;
		end else if (s_r.dec) begin
			if (s_r.tcyc_cnt + 7'h01 >= cyc_lim(s_r.cyc.thr_cyc)) begin
				s_nxt.tcyc_cnt = 7'h00;
				if (thr_on && !quiet) begin
					s_nxt.thr_send = 1'b1;
				end
			end else begin
				s_nxt.tcyc_cnt = s_r.tcyc_cnt + 7'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r      <= '0;
			s_r.cfg  <= CFG_RST;
			s_r.cyc  <= CYC_RST;
			s_r.meas <= SPAN_LO;
			s_r.last <= SPAN_LO;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_ack_out     = s_r.ack;
	assign wb_dat_out     = s_r.dat;
	assign meas_send_out  = s_r.meas_send;
	assign meas_frame_out = s_r.frame;
	assign thr_send_out   = s_r.thr_send;
	assign thr_flag_out   = s_r.flag;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_ack_one_cycle: assert property (@(posedge clk_in) disable iff (rst_in)
		(bus_req && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out)
		else $error("ack not a single cycle after request");

	a_value_in_span: assert property (@(posedge clk_in) disable iff (rst_in)
		meas_send_out |-> (s_r.meas >= SPAN_LO && s_r.meas <= SPAN_HI))
		else $error("reported speed outside span");

	a_thr_off_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
		($past(s_r.cfg.mode) == MODE_NONE && $past(s_r.cfg.mode, 2) == MODE_NONE)
		|-> !thr_send_out)
		else $error("threshold sent while disabled");

	a_never_sent: assert property (@(posedge clk_in) disable iff (rst_in)
		(!$past(s_r.cfg.soc) && $past(s_r.cyc.thr_cyc) == 7'h00) |-> !thr_send_out)
		else $error("threshold sent with sending disabled");

	a_flag_change_sent: assert property (@(posedge clk_in) disable iff (rst_in)
		($past(s_r.cfg.soc) && $changed(thr_flag_out)) |-> thr_send_out)
		else $error("flag change not sent");

	sequence teach_cmd;
		s_r.cfg.ext == EXT_TEACH && teach_in && !dl_fire;
	endsequence
	a_teach_capture: assert property (@(posedge clk_in) disable iff (rst_in)
		teach_cmd |=> (s_r.ext_ok && s_r.ext_val == $past(s_r.meas)))
		else $error("teach did not store current speed");

	a_download_level: assert property (@(posedge clk_in) disable iff (rst_in)
		(dl_fire && !ext16_valid_in && !ext8_valid_in && !teach_in)
		|=> level == wsm_level(s_r.cfg.lvl))
		else $error("external level survived download");

	a_hyst_band_hold: assert property (@(posedge clk_in) disable iff (rst_in)
		(thr_on && rising && {1'b0, s_r.meas} <= {1'b0, level}
		&& {1'b0, s_r.meas} >= lo_lvl) |=> $stable(s_r.raw))
		else $error("comparator moved inside hysteresis band");

	a_change_delay: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(s_r.chg_pend) |-> !chg_go [*8])
		else $error("change send came before the delay");

	// a settings write may shorten a running delay, so only quiet settings count
	sequence dly_wait;
		s_r.dly_run && !s_r.tick && $stable(s_r.cfg);
	endsequence
	a_delay_holds_flag: assert property (@(posedge clk_in) disable iff (rst_in)
		dly_wait |=> $stable(thr_flag_out))
		else $error("flag accepted before its delay ran out");

	a_quiet_no_send: assert property (@(posedge clk_in) disable iff (rst_in)
		(thr_on && quiet) |=> !thr_send_out)
		else $error("telegram sent for a no-telegram condition");

	a_off_flag_still: assert property (@(posedge clk_in) disable iff (rst_in)
		!thr_on |=> $stable(thr_flag_out))
		else $error("flag moved with thresholds disabled");

	sequence rise_above;
		thr_on && rising && s_r.meas > level;
	endsequence
	sequence rise_below;
		thr_on && rising && {1'b0, s_r.meas} < lo_lvl;
	endsequence
	a_rise_compare: assert property (@(posedge clk_in) disable iff (rst_in)
		rise_above |=> s_r.raw)
		else $error("exceeding the level did not set the comparator");
	a_rise_release: assert property (@(posedge clk_in) disable iff (rst_in)
		rise_below |=> !s_r.raw)
		else $error("dropping below the lower level kept the comparator");

	sequence fall_below;
		thr_on && !rising && s_r.meas < level;
	endsequence
	sequence fall_above;
		thr_on && !rising && {1'b0, s_r.meas} > hi_lvl;
	endsequence
	a_fall_compare: assert property (@(posedge clk_in) disable iff (rst_in)
		fall_below |=> s_r.raw)
		else $error("dropping below the level did not set the comparator");
	a_fall_release: assert property (@(posedge clk_in) disable iff (rst_in)
		fall_above |=> !s_r.raw)
		else $error("exceeding the upper level kept the comparator");

	a_prompt_accept: assert property (@(posedge clk_in) disable iff (rst_in)
		(thr_on && !quiet && dly_tgt == 12'h000) |=> thr_flag_out == $past(want))
		else $error("flag not taken at once without a delay");

endmodule

`default_nettype wire

/* File: sim/wsm_bus_partner.sv */
// bus-side partner: counts telegrams and plays the outside threshold source
`timescale 1ns/1ps
`default_nettype none

module wsm_bus_partner (
	input  wire logic        clk_in,
	input  wire logic        meas_send_in,
	input  wire logic [15:0] meas_frame_in,
	input  wire logic        thr_send_in,
	input  wire logic        thr_flag_in,
	output logic             ext16_valid_out,
	output logic      [15:0] ext16_out,
	output logic             ext8_valid_out,
	output logic      [7:0]  ext8_out,
	output logic             teach_out
);
	int          n_meas     = 0;
	int          n_thr      = 0;
	logic [15:0] last_frame = 16'h0000;
	logic        last_flag  = 1'b0;

	initial begin
		ext16_valid_out = 1'b0;
		ext16_out       = 16'h0000;
		ext8_valid_out  = 1'b0;
		ext8_out        = 8'h00;
		teach_out       = 1'b0;
	end

	// ---------------------------------------------------------------
	// telegram sink
	// ---------------------------------------------------------------
	always @(posedge clk_in) begin
		if (meas_send_in === 1'b1) begin
			n_meas     <= n_meas + 1;
			last_frame <= meas_frame_in;
		end
		if (thr_send_in === 1'b1) begin
			n_thr     <= n_thr + 1;
			last_flag <= thr_flag_in;
		end
	end

	// ---------------------------------------------------------------
	// outside threshold objects; released data shows the inverse
	// ---------------------------------------------------------------
	task automatic send_ext16(input logic [15:0] v);
		ext16_out       <= v;
		ext16_valid_out <= 1'b1;
		@(posedge clk_in);
		ext16_valid_out <= 1'b0;
		ext16_out       <= ~v;
		@(posedge clk_in);
	endtask

	task automatic send_ext8(input logic [7:0] v);
		ext8_out       <= v;
		ext8_valid_out <= 1'b1;
		@(posedge clk_in);
		ext8_valid_out <= 1'b0;
		ext8_out       <= ~v;
		@(posedge clk_in);
	endtask

	task automatic store_cmd();
		teach_out <= 1'b1;
		@(posedge clk_in);
		teach_out <= 1'b0;
		@(posedge clk_in);
	endtask
endmodule
`default_nettype wire

/* File: sim/wsm_monitor_bench.sv */
// self-checking bench of the wind speed threshold monitor
`timescale 1ns/1ps
`default_nettype none

module wsm_monitor_bench
	import wsm_pkg::*;
;
	localparam int unsigned TK = 20;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we  = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0000_0000;
	logic [31:0] wb_q;
	logic        wb_ack;
	logic        mvalid = 1'b0;
	logic [15:0] meas   = 16'h0000;
	logic        e16v, e8v, teach, msend, tsend, tflag;
	logic [15:0] e16, frame;
	logic [7:0]  e8;
	int          n_errors = 0;
	int          checks   = 0;
	int          n, t0, m0;

	always #20 clk_in = ~clk_in;

	wsm_monitor #(.TICK_CYCLES(TK)) dut (.clk_in(clk_in), .rst_in(rst_in),
		.wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
		.wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_dat_out(wb_q), .wb_ack_out(wb_ack),
		.meas_valid_in(mvalid), .meas_in(meas), .ext16_valid_in(e16v), .ext16_in(e16),
		.ext8_valid_in(e8v), .ext8_in(e8), .teach_in(teach), .meas_send_out(msend),
		.meas_frame_out(frame), .thr_send_out(tsend), .thr_flag_out(tflag));

	wsm_bus_partner partner (.clk_in(clk_in), .meas_send_in(msend), .meas_frame_in(frame),
		.thr_send_in(tsend), .thr_flag_in(tflag), .ext16_valid_out(e16v), .ext16_out(e16),
		.ext8_valid_out(e8v), .ext8_out(e8), .teach_out(teach));

	// ---------------------------------------------------------------
	// verdict and comparisons
	// ---------------------------------------------------------------
	task automatic test_done();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic to_fail();
		n_errors++;
		$display("[FAIL] t=%0t wait ran out", $time);
		test_done();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input int v, input int lo, input int hi);
		checks++;
		if (v < lo || v > hi) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
		end
	endtask

	// ---------------------------------------------------------------
	// access tasks; every call starts just after a rising edge
	// ---------------------------------------------------------------
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= w;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= 4'hF;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_in);
			if (wb_ack === 1'b1) break;
		end
		if (i == 50) to_fail();
		q = wb_q;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
		@(posedge clk_in);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
		logic [31:0] q;
		wb(1'b0, a, 32'h0000_0000, q);
		chk(q & mask, exp);
	endtask

	task automatic pm(input logic [15:0] v);
		mvalid <= 1'b1;
		meas   <= v;
		@(posedge clk_in);
		mvalid <= 1'b0;
		meas   <= ~v;
		@(posedge clk_in);
	endtask

	task automatic tk(input int c);
		repeat (c) @(posedge clk_in);
	endtask

	task automatic fl(input logic e, input int c);
		tk(c);
		chk({31'h0, tflag}, {31'h0, e});
	endtask

	task automatic wait_meas(output int c);
		int m;
		m = partner.n_meas;
		for (c = 0; c < 400; c++) begin
			@(posedge clk_in);
			if (partner.n_meas != m) break;
		end
		if (c == 400) to_fail();
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		tk(16);
		rst_in <= 1'b0;
		@(posedge clk_in);
		rd(ADR_CFG, CFG_RST, 32'hFFFF_FFFF);
		rd(ADR_CYC, CYC_RST, 32'hFFFF_FFFF);
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
		rd(ADR_CFG, CFG_RST, 32'hFFFF_FFFF);
		tk(250);
		// no threshold: value path only, 12.8 m/s against a 10 m/s level
		t0 = partner.n_thr;
		wr(ADR_CFG, 32'h0200_0140);
		pm(16'h0500);
		wait_meas(n);
		chk_rng(n, 9 * TK - 10, 10 * TK + 15);
		chk({16'h0, partner.last_frame}, 32'h0000_0500);
		chk_rng(partner.n_thr - t0, 0, 0);
		// 30 m/s needs one exponent step: mantissa 1500, exponent 1
		pm(16'h0BB8);
		wait_meas(n);
		chk({16'h0, partner.last_frame}, 32'h0000_0DDC);
		// rising mode with 1 m/s hysteresis
		wr(ADR_CFG, 32'h0200_0141);
		fl(1'b1, 5);
		rd(ADR_LEVEL, 32'h0000_03E8, 32'h0000_FFFF);
		pm(16'h03B6);
		fl(1'b1, 5);
		pm(16'h0383);
		fl(1'b0, 5);
		chk_rng(partner.n_thr - t0, 2, 2);
		chk({31'h0, partner.last_flag}, 32'h0);
		// falling mode
		wr(ADR_CFG, 32'h0200_1141);
		fl(1'b1, 5);
		pm(16'h041A);
		fl(1'b1, 5);
		pm(16'h0484);
		fl(1'b0, 5);
		// ten second on and off delays
		wr(ADR_CFG, 32'h0288_0141);
		fl(1'b0, 9 * TK - 30);
		fl(1'b1, TK + 40);
		pm(16'h0383);
		fl(1'b1, 9 * TK - 30);
		fl(1'b0, TK + 40);
		// outside thresholds, download and teach
		wr(ADR_CFG, 32'h0200_8141);
		partner.send_ext16(16'h0200);
		rd(ADR_LEVEL, 32'h0000_0200, 32'h0000_FFFF);
		wr(ADR_CFG, 32'h0201_0141);
		rd(ADR_LEVEL, 32'h0000_03E8, 32'h0000_FFFF);
		partner.send_ext8(8'h07);
		rd(ADR_LEVEL, 32'h0000_02BC, 32'h0000_FFFF);
		wr(ADR_CFG, 32'h0201_8141);
		partner.store_cmd();
		rd(ADR_LEVEL, 32'h0000_0383, 32'h0000_FFFF);
		// span limits
		pm(16'h1000);
		rd(ADR_STAT, 32'h0000_0BB8, 32'h0000_FFFF);
		pm(16'h0010);
		rd(ADR_STAT, 32'h0000_0064, 32'h0000_FFFF);
		tk(250);
		// cyclic sends of value and flag
		wr(ADR_CFG, 32'h0200_0141);
		wr(ADR_CYC, 32'h0000_0101);
		m0 = partner.n_meas;
		t0 = partner.n_thr;
		tk(100 * TK);
		chk_rng(partner.n_meas - m0, 9, 11);
		chk_rng(partner.n_thr - t0, 9, 11);
		chk({31'h0, partner.last_flag}, 32'h0);
		// no-telegram condition silences the cycle too
		wr(ADR_CFG, 32'h0200_2141);
		t0 = partner.n_thr;
		tk(50 * TK);
		chk_rng(partner.n_thr - t0, 0, 0);
		pm(16'h0500);
		fl(1'b1, 5);
		// no change send and zero cycle: silent
		wr(ADR_CYC, 32'h0000_0000);
		wr(ADR_CFG, 32'h0000_0141);
		t0 = partner.n_thr;
		pm(16'h0383);
		fl(1'b0, 5);
		tk(30 * TK);
		chk_rng(partner.n_thr - t0, 0, 0);
		test_done();
	end
endmodule
`default_nettype wire
